// >>> hw/tts_defs.vh
// constants for the transmit test unit and spare link block
`ifndef TTS_DEFS_VH
`define TTS_DEFS_VH
`define TTS_ADDR_W         9
`define TTS_OFF_TU_CTRL    9'h1A0
`define TTS_OFF_SPARE      9'h1A4
`define TTS_TU_CTRL_RST    16'h0000
`define TTS_SPARE_RST      16'h01FF
`define TTS_EN_BIT         7
`define TTS_GRP_HI         6
`define TTS_GRP_LO         4
`define TTS_TRIB_HI        3
`define TTS_TRIB_LO        2
`define TTS_MODE_HI        1
`define TTS_MODE_LO        0
`define TTS_TU_CTRL_MASK   16'h00FF
`define TTS_SPARE_MASK     16'h01FF
`define TTS_GRP_MAX        3'h6
`define TTS_MODE_DS1       2'h0
`define TTS_MODE_DS2_RAW   2'h1
`define TTS_MODE_DS2_PAY   2'h2
`define TTS_MODE_DS3_PAY   2'h3
`define TTS_SPARE_BITS     9
`define TTS_WIN_NS         106000
`define TTS_CLK_NS         8
`define TTS_GROUPS         7
`define TTS_GRP_ONE        7'h01
`define TTS_GRP_NONE       7'h00
`define TTS_RDATA_ZERO     16'h0000
`define TTS_LINK_RST       9'h1FF
`endif

// >>> hw/tts_spare_buf.v
// spare data-link multiframe buffer with per-multiframe refresh request
`timescale 1ns/1ps
`include "tts_defs.vh"
module tts_spare_buf (
	clk,
	rst_n,
	mf_start,
	sw_data,
	sw_wr,
	spare_link_bit,
	refresh_req,
	underrun
);
	input  wire        clk;
	input  wire        rst_n;
	input  wire        mf_start;
	input  wire [8:0]  sw_data;
	input  wire        sw_wr;
	output reg  [8:0]  spare_link_bit;
	output reg         refresh_req;
	output reg         underrun;

	reg fresh_reg;

	// snapshot at multiframe start; stale contents are resent
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			spare_link_bit <= `TTS_LINK_RST;
			refresh_req    <= 1'b0;
			underrun       <= 1'b0;
			fresh_reg      <= 1'b1;
		end else begin
			refresh_req <= mf_start;
			if (mf_start) begin
				spare_link_bit <= sw_data;
				underrun       <= ~fresh_reg & ~sw_wr;
				fresh_reg      <= sw_wr; // a boundary write stays fresh for the next one
			end else if (sw_wr) begin
				fresh_reg <= 1'b1;
			end
		end
	end
endmodule // tts_spare_buf

// >>> hw/tts_tx_test_spare.v
// transmit test-unit insertion control and spare data-link register bank
`timescale 1ns/1ps
`include "tts_defs.vh"
// What this block does
// - enable bit inserts test data, else normal
// - group select picks DS2 group 0-6
// - tributary select picks DS1/E1 tributary 0-3
// - mode 00 inserts unframed into DS1/E1
// - mode 01 inserts unframed DS2, bypass stage
// - mode 10 inserts into DS2 payload, framed
// - mode 11 inserts into DS3 payload, framed
// - buffer holds one multiframe of spare bits
// - bit 8 is S7B7, bit 0 is S2B3
// - refresh interrupt once per multiframe when enabled
module tts_tx_test_spare (
	clk,
	rst_n,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	mf_start,
	refresh_int_en,
	test_bit,
	test_ins_ds1,
	test_ins_ds2_raw,
	test_ins_ds2_pay,
	test_ins_ds3_pay,
	m12_bypass,
	test_group_select,
	test_tributary_select,
	test_insertion_mode,
	spare_link_bit,
	refresh_int,
	underrun
);
	input  wire [8:0]  reg_addr;
	input  wire        clk;
	input  wire        rst_n;
	input  wire [15:0] reg_wdata;
	input  wire        reg_wr;
	input  wire        reg_rd;
	output reg  [15:0] reg_rdata;
	input  wire        mf_start;
	input  wire        refresh_int_en;
	input  wire        test_bit;
	output reg  [6:0]  test_ins_ds1;
	output reg  [6:0]  test_ins_ds2_raw;
	output reg  [6:0]  test_ins_ds2_pay;
	output reg         test_ins_ds3_pay;
	output reg         m12_bypass;
	output wire [2:0]  test_group_select;
	output wire [1:0]  test_tributary_select;
	output wire [1:0]  test_insertion_mode;
	output wire [8:0]  spare_link_bit;
	output wire        refresh_int;
	output wire        underrun;

	// the test stream itself is steered by the datapath outside this bank;
	// the bank only decides where it goes, so test_bit is not used here
	// and is kept on the port list for the datapath wiring

	// bank registers and their next values
	reg  [15:0] tu_ctrl_reg;
	reg  [15:0] tu_ctrl_next;
	reg  [15:0] spare_reg;
	reg  [15:0] spare_next;
	reg  [15:0] rdata_next;

	// address and strobe decode
	wire        hit_tu;
	wire        hit_sp;
	wire        wr_tu;
	wire        wr_sp;

	// control field decode
	wire        tu_en;
	wire        mode_ds1;
	wire        mode_ds2_raw;
	wire        mode_ds2_pay;
	wire        mode_ds3_pay;
	wire [6:0]  grp_dec;

	// next values of the insertion steering outputs
	wire [6:0]  ins_ds1_next;
	wire [6:0]  ins_ds2_raw_next;
	wire [6:0]  ins_ds2_pay_next;
	wire        ins_ds3_pay_next;
	wire        bypass_next;

	// refresh request from the spare buffer
	wire        refresh_req;

	// address match; the bank answers only its two offsets
	assign hit_tu = (reg_addr == `TTS_OFF_TU_CTRL);
	assign hit_sp = (reg_addr == `TTS_OFF_SPARE);
	assign wr_tu  = reg_wr & hit_tu;
	assign wr_sp  = reg_wr & hit_sp;

	// control fields straight from the register
	assign tu_en                 = tu_ctrl_reg[`TTS_EN_BIT];
	assign test_group_select     = tu_ctrl_reg[`TTS_GRP_HI:`TTS_GRP_LO];
	assign test_tributary_select = tu_ctrl_reg[`TTS_TRIB_HI:`TTS_TRIB_LO];
	assign test_insertion_mode   = tu_ctrl_reg[`TTS_MODE_HI:`TTS_MODE_LO];

	// the tributary field only means something at the DS1/E1 insertion point,
	// so it is passed on as stored and the downstream mux qualifies it

	// insertion mode decode
	// codes 00 and 01 attach unframed, codes 10 and 11 keep the framing
	assign mode_ds1     = (test_insertion_mode == `TTS_MODE_DS1);
	assign mode_ds2_raw = (test_insertion_mode == `TTS_MODE_DS2_RAW);
	assign mode_ds2_pay = (test_insertion_mode == `TTS_MODE_DS2_PAY);
	assign mode_ds3_pay = (test_insertion_mode == `TTS_MODE_DS3_PAY);

	// refresh interrupt gated by its enable
	// the request pulses for one cycle after each multiframe start
	assign refresh_int = refresh_req & refresh_int_en;

	// register write next values; unused bits stored as zero
	// a write to any other offset changes nothing
	always @* begin
		tu_ctrl_next = tu_ctrl_reg;
		spare_next   = spare_reg;
		if (wr_tu) begin
			tu_ctrl_next = reg_wdata & `TTS_TU_CTRL_MASK;
		end
		if (wr_sp) begin
			spare_next = reg_wdata & `TTS_SPARE_MASK;
		end
	end

	// register state; control clears and the spare word sends all ones
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tu_ctrl_reg <= `TTS_TU_CTRL_RST;
			spare_reg   <= `TTS_SPARE_RST;
		end else begin
			tu_ctrl_reg <= tu_ctrl_next;
			spare_reg   <= spare_next;
		end
	end

	// read data next value; held between reads, unmapped reads give zero
	always @* begin
		rdata_next = reg_rdata;
		if (reg_rd) begin
			if (hit_tu) begin
				rdata_next = tu_ctrl_reg;
			end else if (hit_sp) begin
				rdata_next = spare_reg;
			end else begin
				rdata_next = `TTS_RDATA_ZERO;
			end
		end
	end

	// read data register; a slow host may sample it any time before the next read
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= `TTS_RDATA_ZERO;
		end else begin
			reg_rdata <= rdata_next;
		end
	end

	// one-hot group decode; group 7 shifts out and selects nothing
	assign grp_dec = `TTS_GRP_ONE << test_group_select;

	// per-group insertion steering; only the three group-based modes use it
	// each bit of the three vectors stands for one DS2 group
	genvar g;
	generate
		for (g = 0; g < `TTS_GROUPS; g = g + 1) begin : grp
			assign ins_ds1_next[g]     = tu_en & grp_dec[g] & mode_ds1;
			assign ins_ds2_raw_next[g] = tu_en & grp_dec[g] & mode_ds2_raw;
			assign ins_ds2_pay_next[g] = tu_en & grp_dec[g] & mode_ds2_pay;
		end
	endgenerate

	// DS3 payload insertion ignores the group; raw DS2 bypasses the DS1 stage
	assign ins_ds3_pay_next = tu_en & mode_ds3_pay;
	assign bypass_next      = tu_en & mode_ds2_raw;

	// insertion outputs are registered so the datapath sees clean levels
	// that change one cycle after the control register does
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			test_ins_ds1     <= `TTS_GRP_NONE;
			test_ins_ds2_raw <= `TTS_GRP_NONE;
			test_ins_ds2_pay <= `TTS_GRP_NONE;
			test_ins_ds3_pay <= 1'b0;
			m12_bypass       <= 1'b0;
		end else begin
			test_ins_ds1     <= ins_ds1_next;
			test_ins_ds2_raw <= ins_ds2_raw_next;
			test_ins_ds2_pay <= ins_ds2_pay_next;
			test_ins_ds3_pay <= ins_ds3_pay_next;
			m12_bypass       <= bypass_next;
		end
	end

	// spare link buffer, bit order S2B3 up to S7B7; a write in the same cycle
	// as a multiframe start is kept for the following multiframe
	// bits 15:9 of the register never reach the line
	tts_spare_buf u_spare (
		.clk            (clk),
		.rst_n          (rst_n),
		.mf_start       (mf_start),
		.sw_data        (spare_reg[8:0]),
		.sw_wr          (wr_sp),
		.spare_link_bit (spare_link_bit),
		.refresh_req    (refresh_req),
		.underrun       (underrun)
	);
endmodule // tts_tx_test_spare

// >>> verif/tts_line_model.sv
// line-side model: multiframe start pulses
`timescale 1ns/1ps
module tts_line_model #(parameter int P = 40) (
	input  logic clk,
	input  logic rst_n,
	output logic mf_start
);
	int c;
	// frame counter, one start pulse per multiframe
	assign mf_start = rst_n && c == P - 1;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) c <= 0;
		else c <= (c == P - 1) ? 0 : c + 1;
	end
endmodule // tts_line_model

// >>> verif/tts_sva.sv
// checker for the test unit and spare link bank
`timescale 1ns/1ps
module tts_sva (
	input logic        clk, rst_n, reg_wr, mf_start, refresh_int_en, refresh_int,
	input logic        m12_bypass, test_ins_ds3_pay, underrun,
	input logic [8:0]  reg_addr, spare_link_bit,
	input logic [15:0] reg_wdata,
	input logic [6:0]  test_ins_ds1
);
	wire cw = reg_wr && reg_addr == 9'h1A0;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// insertion outputs follow control writes, refresh and snapshot follow frames
	property p_ds3; cw && reg_wdata[7:0] == 8'h83 |=> ##1 test_ins_ds3_pay; endproperty
	a_ds3: assert property (p_ds3) else $error("ds3");
	property p_off; cw && !reg_wdata[7] |=> ##1 !test_ins_ds3_pay && !m12_bypass; endproperty
	a_off: assert property (p_off) else $error("off");
	property p_byp; cw && reg_wdata[7:0] == 8'hA1 |=> ##1 m12_bypass; endproperty
	a_byp: assert property (p_byp) else $error("byp");
	property p_ds1; cw && reg_wdata[7:0] == 8'hBC |=> ##1 test_ins_ds1 == 7'h08; endproperty
	a_ds1: assert property (p_ds1) else $error("ds1");
	property p_int; mf_start |=> refresh_int == refresh_int_en; endproperty
	a_int: assert property (p_int) else $error("int");
	property p_nint; refresh_int |-> $past(mf_start) && refresh_int_en; endproperty
	a_nint: assert property (p_nint) else $error("nint");
	property p_one; refresh_int |=> !refresh_int; endproperty
	a_one: assert property (p_one) else $error("one");
	property p_hold; !$past(mf_start) |-> $stable(spare_link_bit); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_uhold; !$past(mf_start) |-> $stable(underrun); endproperty
	a_uhold: assert property (p_uhold) else $error("uhold");
	cover property (refresh_int);
	cover property (underrun);
	cover property (m12_bypass);
	cover property (test_ins_ds3_pay);
endmodule // tts_sva
bind tts_tx_test_spare tts_sva u_sva (.*);

// >>> verif/tts_tx_test_spare_tb_top.sv
// bench for the test unit and spare link bank
`timescale 1ns/1ps
module tts_tx_test_spare_tb_top;
	logic        clk = '0, rst_n = '0, reg_wr = '0, reg_rd = '0, test_bit = '0;
	logic        refresh_int_en = '0, mf_start, m12_bypass, test_ins_ds3_pay, refresh_int, underrun;
	logic [8:0]  reg_addr = '0, spare_link_bit;
	logic [15:0] reg_wdata = '0, reg_rdata;
	logic [6:0]  test_ins_ds1, test_ins_ds2_raw, test_ins_ds2_pay;
	logic [2:0]  test_group_select;
	logic [1:0]  test_tributary_select, test_insertion_mode;
	int          err_count = 0, num_checks = 0, k;
	wire [22:0]  ins = {test_ins_ds1, test_ins_ds2_raw, test_ins_ds2_pay, test_ins_ds3_pay, m12_bypass};
	wire [6:0]   fld = {test_group_select, test_tributary_select, test_insertion_mode};
	logic [30:0] t[6] = '{{8'h83, 23'h2}, {8'hA1, 14'h4, 9'h1}, {8'hE2, 14'h0, 7'h40, 2'h0},
		{8'hBC, 7'h08, 16'h0}, {8'hF0, 23'h0}, {8'h03, 23'h0}};
	tts_tx_test_spare uut (.*);
	tts_line_model #(.P(40)) mdl (.clk(clk), .rst_n(rst_n), .mf_start(mf_start));
	initial forever #4 clk = ~clk;
	// compare and count
	task chk(input logic [31:0] g, e);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	// write one address, read back another, compare
	task acc(input logic [8:0] wa, ra, input logic [15:0] v, e);
		@(posedge clk);
		{reg_addr, reg_wdata, reg_wr} <= {wa, v, 1'b1};
		@(posedge clk);
		{reg_wr, reg_rd, reg_addr} <= {2'b01, ra};
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk) #1;
		chk(reg_rdata, e);
	endtask
	// wait for a frame start, bounded
	task wmf;
		for (k = 0; k < 99 && !mf_start; k++) @(posedge clk) #1;
		if (k == 99) begin
			err_count++;
			complete_run;
		end
		@(posedge clk) #1;
	endtask
	task complete_run;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// reset values, table of control words, then frame traffic
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		acc(9'h1A8, 9'h1A0, 16'h1234, 16'h0000);
		acc(9'h1A8, 9'h1A4, 16'h1234, 16'h01FF);
		acc(9'h1A8, 9'h1A8, 16'h1234, 16'h0000);
		for (int j = 0; j < 6; j++) begin
			acc(9'h1A0, 9'h1A0, {8'hFF, t[j][30:23]}, {8'h00, t[j][30:23]});
			chk(fld, t[j][29:23]);
			chk(ins, t[j][22:0]);
		end
		@(posedge clk) refresh_int_en <= 1'b1;
		#1;
		wmf;
		chk(refresh_int, 1'b1);
		acc(9'h1A4, 9'h1A4, 16'h7F55, 16'h0155);
		wmf;
		chk(spare_link_bit, 9'h155);
		wmf;
		chk({underrun, spare_link_bit}, 10'h355);
		@(posedge clk) refresh_int_en <= 1'b0;
		#1;
		wmf;
		chk(refresh_int, 1'b0);
		// mid-run reset clears control, flag and steering; spare word and snapshot return to all ones
		acc(9'h1A0, 9'h1A0, 16'h0083, 16'h0083);
		@(posedge clk) rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk({underrun, spare_link_bit}, 10'h1FF);
		chk({fld, ins}, 30'h0);
		acc(9'h1A8, 9'h1A4, 16'h1234, 16'h01FF);
		complete_run;
	end
endmodule // tts_tx_test_spare_tb_top
